// >>> abu_address_breakpoint_unit.sv
/*
  address breakpoint unit: compares cpu addresses to a breakpoint, requests
  a forced trap instruction toward system integration logic, holds the break state
  for timer stop, watchdog disable and flag clear protection.
  assumes a 32-bit classic wishbone master and cpu status signals on i_mclk.
*/
`include "abu_cfg.svh"
module abu_address_breakpoint_unit
  import abu_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // cpu side
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic        i_cpu_addr_valid,
  input  wire logic        i_cpu_opcode_fetch,
  input  wire logic        i_cpu_instr_end,
  input  wire logic        i_cpu_int_return,
  input  wire logic        i_cpu_wait,
  input  wire logic        i_cpu_stop,
  input  wire logic        i_wait_exit,
  input  wire logic        i_monitor_mode,
  // system integration side
  input  wire logic        i_break_taken,
  output logic             o_breakpoint_request,
  output logic             o_force_trap,
  output logic      [7:0]  o_trap_opcode,
  output logic      [15:0] o_break_vector,
  output logic             o_break_state,
  output logic             o_timer_halt,
  output logic             o_watchdog_disable,
  output logic             o_flag_clear_allow,
  output logic             o_irq
);

  logic [7:0]  addr_hi_q;
  logic [7:0]  addr_lo_q;
  logic        ena_q;
  logic        act_q;
  logic        wddis_q;
  logic        cfe_q;
  logic        wexit_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_en_q;
  abu_state_t  state_q;
  logic        defer_q;
  logic        armed_q;
  logic        wb_req;
  logic        wr;
  logic        wr_lane0;
  logic        match;
  logic        sw_break;
  logic        req_now;
  logic [7:0]  rd_byte;
  logic        state_q_is_break;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  assign wb_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr       = wb_req & i_wb_we;
  assign wr_lane0 = wr & i_wb_sel[0];
  // no match while the address bus is frozen in wait or stop
  assign match    = ena_q & i_cpu_addr_valid & ~i_cpu_wait & ~i_cpu_stop
                    & (i_cpu_addr == {addr_hi_q, addr_lo_q}); // RQ1 RQ17
  assign sw_break = wr_lane0 & hit(i_wb_adr, `ABU_OFS_SCR) & i_wb_dat[`ABU_BIT_ACT]; // RQ4
  // a set active bit, or an address not rewritten since the
  // last match-driven break, blocks another match-driven one
  assign req_now  = (match & ~act_q & armed_q) | sw_break; // RQ8
  assign state_q_is_break = (state_q == ABU_BREAK);

  // single-cycle ack; unmapped reads return zero, writes ignored
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_wb_ack <= 1'b0;
    else
      o_wb_ack <= wb_req;
  end

  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(i_wb_adr, `ABU_OFS_SCR))
      rd_byte = {ena_q, act_q, 6'h00};
    else if (hit(i_wb_adr, `ABU_OFS_ADRH))
      rd_byte = addr_hi_q;
    else if (hit(i_wb_adr, `ABU_OFS_ADRL))
      rd_byte = addr_lo_q;
    else if (hit(i_wb_adr, `ABU_OFS_AUX))
      rd_byte = {7'h00, wddis_q};
    else if (hit(i_wb_adr, `ABU_OFS_WSR))
      rd_byte = {6'h00, wexit_q, 1'b0};
    else if (hit(i_wb_adr, `ABU_OFS_FCR))
      rd_byte = {cfe_q, 7'h00};
    else if (hit(i_wb_adr, `ABU_OFS_IST))
      rd_byte = {6'h00, irq_st_q};
    else if (hit(i_wb_adr, `ABU_OFS_IEN))
      rd_byte = {6'h00, irq_en_q};
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_wb_dat <= 32'h0000_0000;
    else if (wb_req && !i_wb_we)
      o_wb_dat <= {24'h00_0000, rd_byte};
  end

  // break address bytes
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      addr_hi_q <= `ABU_RST_BYTE; // RQ12
      addr_lo_q <= `ABU_RST_BYTE;
    end
    else
    begin
      if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_ADRH))
        addr_hi_q <= i_wb_dat[7:0]; // RQ12
      if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_ADRL))
        addr_lo_q <= i_wb_dat[7:0];
    end
  end

  // enable and config bits
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ena_q   <= 1'b0; // RQ10
      wddis_q <= 1'b0; // RQ15
      cfe_q   <= 1'b0;
    end
    else
    begin
      if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_SCR))
        ena_q <= i_wb_dat[`ABU_BIT_ENA]; // RQ10
      if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_AUX))
        wddis_q <= i_wb_dat[`ABU_BIT_WDDIS];
      if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_FCR))
        cfe_q <= i_wb_dat[`ABU_BIT_CFE];
    end
  end

  // active bit: a match in the same cycle as a software clear wins
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      act_q <= 1'b0; // RQ11
    else if (match)
      act_q <= 1'b1; // RQ3
    else if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_SCR))
      act_q <= i_wb_dat[`ABU_BIT_ACT];
  end

  // disarmed by a match-driven break until the address is written again
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      armed_q <= 1'b1;
    else if (wr_lane0 && (hit(i_wb_adr, `ABU_OFS_ADRH) || hit(i_wb_adr, `ABU_OFS_ADRL)))
      armed_q <= 1'b1; // RQ8
    else if (state_q == ABU_IDLE && match && !act_q)
      armed_q <= 1'b0; // RQ8
  end

  // wait exit flag: set when the break ends a wait, cleared by writing zero
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      wexit_q <= 1'b0;
    else if (i_wait_exit && state_q != ABU_IDLE)
      wexit_q <= 1'b1; // RQ16
    else if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_WSR) && !i_wb_dat[`ABU_BIT_WEXIT])
      wexit_q <= 1'b0;
  end

  // break sequencing; opcode hits wait for nothing, operand hits and
  // software requests wait for the current instruction to finish
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= ABU_IDLE;
      defer_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ABU_IDLE:
        begin
          if (req_now)
          begin
            state_q <= ABU_PENDING;
            defer_q <= sw_break | ~i_cpu_opcode_fetch; // RQ6 RQ7
          end
        end
        ABU_PENDING:
        begin
          if (i_cpu_instr_end)
            defer_q <= 1'b0; // RQ7
          if (i_break_taken)
            state_q <= ABU_BREAK; // RQ18
        end
        ABU_BREAK:
        begin
          if (i_cpu_int_return)
            state_q <= ABU_IDLE; // RQ5
        end
        default:
          state_q <= ABU_IDLE;
      endcase
    end
  end

  // request and forced instruction toward system integration logic
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_breakpoint_request <= 1'b0;
      o_force_trap         <= 1'b0;
      o_trap_opcode        <= 8'h00;
      o_break_vector       <= `ABU_VEC_NORMAL;
    end
    else
    begin
      o_breakpoint_request <= (state_q == ABU_PENDING) && !i_break_taken; // RQ1
      o_force_trap         <= (state_q == ABU_PENDING) && !i_break_taken
                              && (!defer_q || i_cpu_instr_end); // RQ2 RQ6
      o_trap_opcode        <= `ABU_OP_TRAP; // RQ2
      o_break_vector       <= i_monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL; // RQ2
    end
  end

  // break state side effects
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_break_state      <= 1'b0;
      o_timer_halt       <= 1'b0;
      o_watchdog_disable <= 1'b0;
      o_flag_clear_allow <= 1'b1;
    end
    else
    begin
      o_break_state      <= state_q_is_break; // RQ18
      o_timer_halt       <= state_q_is_break; // RQ14
      o_watchdog_disable <= state_q_is_break & i_monitor_mode & wddis_q; // RQ15
      o_flag_clear_allow <= ~state_q_is_break | cfe_q; // RQ13
    end
  end

  // interrupt: bit0 break entry, bit1 break exit; set wins over clear
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      irq_st_q <= 2'b00;
      irq_en_q <= 2'b00;
      o_irq    <= 1'b0;
    end
    else
    begin
      irq_st_q <= (irq_st_q & ~((wr_lane0 && hit(i_wb_adr, `ABU_OFS_ICLR)) ? i_wb_dat[1:0] : 2'b00))
                  | {(state_q_is_break && i_cpu_int_return),
                     (state_q == ABU_PENDING && i_break_taken)};
      if (wr_lane0 && hit(i_wb_adr, `ABU_OFS_IEN))
        irq_en_q <= i_wb_dat[1:0];
      o_irq <= |(irq_st_q & irq_en_q);
    end
  end

  // assertions
  property p_match_sets_active;
    @(posedge i_mclk) disable iff (!i_nrst)
    match |=> act_q;
  endproperty
  a_match_sets_active: assert property (p_match_sets_active) else $error("match did not set active"); // RQ3

  property p_no_break_when_disabled;
    @(posedge i_mclk) disable iff (!i_nrst)
    (!ena_q && !sw_break && state_q == ABU_IDLE) |=> state_q == ABU_IDLE;
  endproperty
  a_no_break_when_disabled: assert property (p_no_break_when_disabled) else $error("break while disabled"); // RQ10

  property p_request_follows_match;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q == ABU_IDLE && match && !act_q && armed_q) |=> ##1 o_breakpoint_request;
  endproperty
  a_request_follows_match: assert property (p_request_follows_match) else $error("no request after match"); // RQ1

  property p_vector_by_mode;
    @(posedge i_mclk) disable iff (!i_nrst)
    i_monitor_mode |=> o_break_vector == `ABU_VEC_MONITOR;
  endproperty
  a_vector_by_mode: assert property (p_vector_by_mode) else $error("wrong monitor vector"); // RQ2

  property p_return_ends_break;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q_is_break && i_cpu_int_return) |=> ##1 !o_break_state && !o_timer_halt;
  endproperty
  a_return_ends_break: assert property (p_return_ends_break) else $error("break not ended"); // RQ5

  property p_timer_halt;
    @(posedge i_mclk) disable iff (!i_nrst)
    state_q_is_break |=> o_timer_halt;
  endproperty
  a_timer_halt: assert property (p_timer_halt) else $error("timer not halted"); // RQ14

  property p_no_rebreak;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q == ABU_IDLE && act_q && !sw_break) |=> state_q == ABU_IDLE;
  endproperty
  a_no_rebreak: assert property (p_no_rebreak) else $error("rebreak with active set"); // RQ8

  property p_flag_protect;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q_is_break && !cfe_q) |=> !o_flag_clear_allow;
  endproperty
  a_flag_protect: assert property (p_flag_protect) else $error("clear not blocked"); // RQ13

  property p_wait_no_match;
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_cpu_wait || i_cpu_stop) |-> !match;
  endproperty
  a_wait_no_match: assert property (p_wait_no_match) else $error("match in low power"); // RQ17

  property p_no_rearm;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q == ABU_IDLE && !armed_q && !sw_break) |=> state_q == ABU_IDLE;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("rebreak on unchanged address"); // RQ8

  property p_sw_break_starts;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q == ABU_IDLE && sw_break) |=> state_q == ABU_PENDING;
  endproperty
  a_sw_break_starts: assert property (p_sw_break_starts) else $error("software break not started"); // RQ4

  property p_opcode_immediate;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q == ABU_IDLE && match && !act_q && armed_q && !sw_break && i_cpu_opcode_fetch) |=> ##1 o_force_trap;
  endproperty
  a_opcode_immediate: assert property (p_opcode_immediate) else $error("opcode break deferred"); // RQ6

  property p_operand_deferred;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q == ABU_PENDING && defer_q && !i_cpu_instr_end) |=> !o_force_trap;
  endproperty
  a_operand_deferred: assert property (p_operand_deferred) else $error("trap before instruction end"); // RQ7

  property p_watchdog_off;
    @(posedge i_mclk) disable iff (!i_nrst)
    (state_q_is_break && i_monitor_mode && wddis_q) |=> o_watchdog_disable;
  endproperty
  a_watchdog_off: assert property (p_watchdog_off) else $error("watchdog not disabled"); // RQ15

  property p_wait_exit_flag;
    @(posedge i_mclk) disable iff (!i_nrst)
    (i_wait_exit && state_q != ABU_IDLE) |=> wexit_q;
  endproperty
  a_wait_exit_flag: assert property (p_wait_exit_flag) else $error("wait exit flag not set"); // RQ16

  c_sw_break: cover property (@(posedge i_mclk) disable iff (!i_nrst) sw_break);
  c_enter_break: cover property (@(posedge i_mclk) disable iff (!i_nrst) state_q == ABU_PENDING ##1 state_q_is_break);
  c_exit_break: cover property (@(posedge i_mclk) disable iff (!i_nrst) state_q_is_break && i_cpu_int_return);
  c_operand_defer: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    state_q == ABU_PENDING && defer_q && i_cpu_instr_end);

endmodule : abu_address_breakpoint_unit

// >>> abu_address_breakpoint_unit_test.sv
/*
  bench for the address breakpoint unit: wishbone register traffic, cpu
  address stimulus and a system logic model. assumes abu_cfg.svh.
*/
`include "abu_cfg.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; $display("Error %s expected %h seen %h", nm, ex, got); end end
`define WAITFOR(c) begin for (w = 0; w < 40 && (c) !== 1'b1; w++) @(posedge i_mclk); if ((c) !== 1'b1) begin fails++; print_verdict(); end end
module abu_address_breakpoint_unit_test
  import abu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_mclk = 1'b0, i_nrst = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [3:0]  i_wb_sel = 4'h0, i_delay = 4'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
  logic [15:0] i_cpu_addr = 16'h0, o_break_vector, bp;
  logic        i_cpu_addr_valid = 1'b0, i_cpu_opcode_fetch = 1'b0, i_cpu_instr_end = 1'b0, i_cpu_int_return = 1'b0;
  logic        i_cpu_wait = 1'b0, i_cpu_stop = 1'b0, i_wait_exit = 1'b0, i_monitor_mode = 1'b0, i_break_taken;
  logic        o_wb_ack, o_breakpoint_request, o_force_trap, o_break_state, o_timer_halt;
  logic        o_watchdog_disable, o_flag_clear_allow, o_irq;
  logic [7:0]  o_trap_opcode, exp_v;
  logic [7:0]  exp_q[$];
  int          fails = 0, n_checks = 0, w, i, seed;

  abu_address_breakpoint_unit i_abu_address_breakpoint_unit (.*);
  abu_sys_logic_model i_abu_sys_logic_model
  (
    .i_mclk        (i_mclk),
    .i_nrst        (i_nrst),
    .i_force_trap  (o_force_trap),
    .i_delay       (i_delay),
    .o_break_taken (i_break_taken)
  );

  always #5 i_mclk = ~i_mclk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat, input logic [3:0] sel);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_dat <= dat;
    i_wb_sel <= sel;
    `WAITFOR(o_wb_ack)
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_mclk);
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    wb(adr, 1'b1, {24'h0, dat}, 4'h1);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [7:0] ex);
    exp_q.push_back(ex);
    wb(adr, 1'b0, 32'h0, 4'hf);
  endtask : rd

  // one-cycle strobes: bit2 return, bit1 instruction end, bit0 wait exit
  task automatic pulse(input logic [2:0] m);
    {i_cpu_int_return, i_cpu_instr_end, i_wait_exit} <= m;
    @(posedge i_mclk);
    {i_cpu_int_return, i_cpu_instr_end, i_wait_exit} <= 3'b000;
  endtask : pulse

  // drive one bus cycle, then move the address off the breakpoint
  task automatic present(input logic opc);
    i_cpu_addr         <= bp;
    i_cpu_addr_valid   <= 1'b1;
    i_cpu_opcode_fetch <= opc;
    @(posedge i_mclk);
    i_cpu_addr_valid   <= 1'b0;
    i_cpu_addr         <= ~bp;
  endtask : present

  task automatic no_break;
    repeat (8) @(posedge i_mclk);
    `CHK("request", 1'b0, o_breakpoint_request)
  endtask : no_break

  // software leaves the routine: clear active, then return
  task automatic end_break;
    wr(`ABU_OFS_SCR, 8'h80);
    pulse(3'b100);
    `WAITFOR(!o_break_state)
    `CHK("timer halt", 1'b0, o_timer_halt)
  endtask : end_break

  always @(posedge i_mclk)
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0 && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK("read data", {24'h00_0000, exp_v}, o_wb_dat)
    end

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    fails++;
    print_verdict();
  end

  initial
  begin
    seed = 32'h192a37de;
    bp = 16'($random(seed));
    repeat (4) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    `CHK("vector", `ABU_VEC_NORMAL, o_break_vector)
    for (i = 0; i < 10; i++)
      rd(8'(i * 4), `ABU_RST_BYTE);
    wr(`ABU_OFS_ADRH, bp[15:8]);
    wr(`ABU_OFS_ADRL, bp[7:0]);
    wb(`ABU_OFS_ADRL, 1'b1, {24'h0, ~bp[7:0]}, 4'he);
    rd(`ABU_OFS_ADRH, bp[15:8]);
    rd(`ABU_OFS_ADRL, bp[7:0]);
    wr(`ABU_OFS_IEN, 8'h03);
    wr(`ABU_OFS_SCR, 8'h80);
    present(1'b1);
    `WAITFOR(o_force_trap)
    `CHK("request", 1'b1, o_breakpoint_request)
    `CHK("opcode", `ABU_OP_TRAP, o_trap_opcode)
    `WAITFOR(o_break_state)
    `CHK("timer halt", 1'b1, o_timer_halt)
    `CHK("clear allow", 1'b0, o_flag_clear_allow)
    `CHK("watchdog", 1'b0, o_watchdog_disable)
    rd(`ABU_OFS_SCR, 8'hc0);
    wr(`ABU_OFS_FCR, 8'h80);
    `CHK("clear allow", 1'b1, o_flag_clear_allow)
    wr(`ABU_OFS_FCR, 8'h00);
    end_break();
    present(1'b1);
    no_break();
    rd(`ABU_OFS_SCR, 8'hc0);
    // reload address and clear active for the next break
    bp = bp ^ 16'h0101;
    wr(`ABU_OFS_ADRH, bp[15:8]);
    wr(`ABU_OFS_ADRL, bp[7:0]);
    wr(`ABU_OFS_SCR, 8'h80);
    present(1'b0);
    repeat (4) @(posedge i_mclk);
    `CHK("force trap", 1'b0, o_force_trap)
    pulse(3'b010);
    `WAITFOR(o_force_trap)
    `WAITFOR(o_break_state)
    end_break();
    i_monitor_mode <= 1'b1;
    i_delay        <= 4'h7;
    wr(`ABU_OFS_AUX, 8'h01);
    wr(`ABU_OFS_SCR, 8'hc0);
    `CHK("request", 1'b1, o_breakpoint_request)
    `CHK("force trap", 1'b0, o_force_trap)
    pulse(3'b010);
    `WAITFOR(o_force_trap)
    `CHK("vector", `ABU_VEC_MONITOR, o_break_vector)
    `WAITFOR(o_break_state)
    @(posedge i_mclk);
    `CHK("watchdog", 1'b1, o_watchdog_disable)
    pulse(3'b001);
    rd(`ABU_OFS_WSR, 8'h02);
    end_break();
    i_monitor_mode <= 1'b0;
    // rewrite the address each pass so only the disable or low power blocks it
    for (i = 0; i < 3; i++)
    begin
      wr(`ABU_OFS_SCR, i ? 8'h80 : 8'h00);
      wr(`ABU_OFS_ADRL, bp[7:0]);
      i_cpu_wait <= (i == 1);
      i_cpu_stop <= (i == 2);
      present(1'b1);
      no_break();
    end
    i_cpu_wait <= 1'b0;
    i_cpu_stop <= 1'b0;
    `CHK("irq", 1'b1, o_irq)
    wr(`ABU_OFS_IEN, 8'h00);
    `CHK("irq", 1'b0, o_irq)
    wr(`ABU_OFS_IEN, 8'h03);
    rd(`ABU_OFS_IST, 8'h03);
    wr(`ABU_OFS_ICLR, 8'h03);
    `CHK("irq", 1'b0, o_irq)
    rd(`ABU_OFS_IST, 8'h00);
    print_verdict();
  end
endmodule : abu_address_breakpoint_unit_test

// >>> abu_cfg.svh
/*
  constants for the address breakpoint unit: register offsets, field
  positions, reset values and vectors. assumes a 32-bit classic wishbone bus.
*/
// Summary of operation
// RQ1 - address match with enable requests break
// RQ2 - force trap instruction, vector by monitor mode
// RQ3 - address match sets break active bit
// RQ4 - writing one to active requests break
// RQ5 - return from interrupt ends break state
// RQ6 - opcode match defers that instruction
// RQ7 - operand match breaks after instruction
// RQ8 - cleared active with same address: no rebreak
// RQ9 - software reloads address for continuous breaks
// RQ10 - enable bit seven, reset clears it
// RQ11 - software clears active; reset clears it
// RQ12 - address bytes read/write, reset to zero
// RQ13 - flag clears blocked in break unless enabled
// RQ14 - timer halted during break state
// RQ15 - watchdog off in monitor break if set
// RQ16 - wait exit flag set by break
// RQ17 - no break in wait or stop
// RQ18 - break state held until return
`ifndef ABU_CFG_SVH
`define ABU_CFG_SVH
`define ABU_OFS_SCR     8'h00
`define ABU_OFS_ADRH    8'h04
`define ABU_OFS_ADRL    8'h08
`define ABU_OFS_AUX     8'h0c
`define ABU_OFS_WSR     8'h10
`define ABU_OFS_FCR     8'h14
`define ABU_OFS_IST     8'h18
`define ABU_OFS_ICLR    8'h1c
`define ABU_OFS_IEN     8'h20
`define ABU_BIT_ENA     7
`define ABU_BIT_ACT     6
`define ABU_BIT_WDDIS   0
`define ABU_BIT_WEXIT   1
`define ABU_BIT_CFE     7
`define ABU_RST_BYTE    8'h00
`define ABU_VEC_NORMAL  16'hfffc
`define ABU_VEC_MONITOR 16'hfefc
`define ABU_OP_TRAP     8'h83
`endif

// >>> abu_pkg.sv
/*
  types for the address breakpoint unit. assumes abu_cfg.svh is alongside.
*/
package abu_pkg;
  typedef enum logic [1:0]
  {
    ABU_IDLE    = 2'b00,
    ABU_PENDING = 2'b01,
    ABU_BREAK   = 2'b10
  } abu_state_t;
  // interrupt status bits: entry, exit
  typedef logic [1:0] abu_irq_t;
endpackage : abu_pkg

// >>> abu_sim_model.sv
/*
  stand-in for the system integration logic: answers a forced trap with one
  taken pulse after a set number of cycles. assumes the unit's clock.
*/
module abu_sys_logic_model
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // break handshake
  input  wire logic       i_force_trap,
  input  wire logic [3:0] i_delay,
  output logic            o_break_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       done_q;
  // one pulse per forced trap; a long delay models an instruction in flight
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q         <= 4'h0;
      done_q        <= 1'b0;
      o_break_taken <= 1'b0;
    end
    else
    begin
      o_break_taken <= i_force_trap && !done_q && cnt_q == i_delay;
      done_q        <= i_force_trap && (done_q || cnt_q == i_delay);
      cnt_q         <= (i_force_trap && cnt_q != i_delay) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : abu_sys_logic_model
